// ---- rtl/uwb_pkg.sv ----
package uwb_pkg;
    // Register offsets (byte addresses, one 32-bit word each).
    localparam logic [3:0] UWB_OFS_CTRL   = 4'h0;
    localparam logic [3:0] UWB_OFS_STATUS = 4'h4;
    localparam logic [3:0] UWB_OFS_RXBUF  = 4'h8;

    // Control register fields.
    localparam int UWB_CTRL_WAKE_BIT  = 0;
    localparam int UWB_CTRL_SYNC_BIT  = 1;
    localparam int UWB_CTRL_SLEEP_BIT = 2;

    // Status register fields.
    localparam int UWB_STAT_RXIF_BIT   = 0;
    localparam int UWB_STAT_IDLE_BIT   = 1;
    localparam int UWB_STAT_LINE_BIT   = 2;
    localparam int UWB_STAT_WAKE_BIT   = 3;
    localparam int UWB_STAT_FRAME_BIT  = 4;

    // Reset values.
    localparam logic       UWB_RST_WAKE  = 1'b0;
    localparam logic       UWB_RST_SYNC  = 1'b0;
    localparam logic       UWB_RST_SLEEP = 1'b0;
    localparam logic [7:0] UWB_RST_RXBUF = 8'h00;

    // Timing: the default bit time and the clock rate.
    localparam int UWB_CLK_HZ      = 200_000_000;
    localparam int UWB_BAUD        = 9600;
    localparam int UWB_BIT_CYCLES  = UWB_CLK_HZ / UWB_BAUD;

    // Receiver states, Gray coded along the usual path.
    typedef enum logic [2:0]
    {
        UWB_IDLE  = 3'b000,
        UWB_START = 3'b001,
        UWB_DATA  = 3'b011,
        UWB_STOP  = 3'b010,
        UWB_WAKE  = 3'b110
    } uwb_state_t;
endpackage

// ---- rtl/uwb_line_sync.sv ----
`timescale 1ns/100ps
// Three-stage synchroniser for the receive pin; a change counts once
// stages two and three agree. Edge pulses come from registered stages only.
module uwb_line_sync
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // Pin side
    input  wire logic pinIn,
    // Filtered line and edges
    output logic      lineLevel,
    output logic      fallPulse,
    output logic      risePulse
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            stage1 <= 1'b1;
            stage2 <= 1'b1;
            stage3 <= 1'b1;
        end
        else
        begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            lineLevel <= 1'b1;
            fallPulse <= 1'b0;
            risePulse <= 1'b0;
        end
        else
        begin
            fallPulse <= 1'b0;
            risePulse <= 1'b0;
            if (stage2 == stage3 && stage3 != lineLevel)
            begin
                lineLevel <= stage3;
                fallPulse <= ~stage3;
                risePulse <= stage3;
            end
        end
    end
endmodule

// ---- rtl/uwb_wake_uart.sv ----
`timescale 1ns/100ps
module uwb_wake_uart
    import uwb_pkg::*;
#(
    parameter int BIT_CYCLES = uwb_pkg::UWB_BIT_CYCLES
)
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // Serial line
    input  wire logic        receiveLinePin,
    // Status outputs
    output logic             receiveInterruptFlag,
    output logic             wakeOnBreakEnable
);
    import uwb_pkg::*;

    localparam int CW = $clog2(BIT_CYCLES + 1);

    logic            lineLevel;
    logic            fallPulse;
    logic            risePulse;
    logic            syncMode;
    logic            sleepMode;
    logic            frameError;
    logic [7:0]      receiveBufferRegister;
    logic [7:0]      shiftReg;
    logic [2:0]      bitIndex;
    logic [CW-1:0]   baudCount;
    uwb_state_t      state;
    logic            charDone;
    logic            ackPending;
    logic            busAccess;
    logic            bufRead;
    logic            ctrlWrite;
    logic            wakeEvent;
    logic            breakEnd;
    logic            baudRun;
    logic            armed;

    // Pin capture through three flops into the running clock.
    // synchronised edge capture
    uwb_line_sync u_line_sync
    (
        .clock     (clock),
        .rst       (rst),
        .pinIn     (receiveLinePin),
        .lineLevel (lineLevel),
        .fallPulse (fallPulse),
        .risePulse (risePulse)
    );

    // One wait state per access so read data always come from a register.
    assign busAccess = (read || write) && !ackPending;
    assign bufRead   = read && ackPending && (address == UWB_OFS_RXBUF);
    assign ctrlWrite = write && ackPending && (address == UWB_OFS_CTRL);

    assign armed     = wakeOnBreakEnable && !syncMode;
    assign wakeEvent = armed && fallPulse && state == UWB_IDLE;
    assign breakEnd  = armed && risePulse && state == UWB_WAKE;
    assign baudRun   = !sleepMode && !syncMode;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ackPending  <= 1'b0;
            waitrequest <= 1'b1;
        end
        else
        begin
            ackPending  <= busAccess;
            waitrequest <= !busAccess;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            readdata <= 32'h0000_0000;
        end
        else if (read && !ackPending)
        begin
            readdata <= 32'h0000_0000;
            case (address)
                UWB_OFS_CTRL:
                begin
                    readdata[UWB_CTRL_WAKE_BIT]  <= wakeOnBreakEnable;
                    readdata[UWB_CTRL_SYNC_BIT]  <= syncMode;
                    readdata[UWB_CTRL_SLEEP_BIT] <= sleepMode;
                end
                UWB_OFS_STATUS:
                begin
                    readdata[UWB_STAT_RXIF_BIT]  <= receiveInterruptFlag;
                    readdata[UWB_STAT_IDLE_BIT]  <= (state == UWB_IDLE);
                    readdata[UWB_STAT_LINE_BIT]  <= lineLevel;
                    readdata[UWB_STAT_WAKE_BIT]  <= (state == UWB_WAKE);
                    readdata[UWB_STAT_FRAME_BIT] <= frameError;
                end
                UWB_OFS_RXBUF:
                begin
                    readdata[7:0] <= receiveBufferRegister;
                end
                default:
                begin
                    readdata <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Mode bits; hardware clear of wake enable beats a software write.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wakeOnBreakEnable <= UWB_RST_WAKE;
            syncMode          <= UWB_RST_SYNC;
            sleepMode         <= UWB_RST_SLEEP;
        end
        else
        begin
            if (ctrlWrite)
            begin
                wakeOnBreakEnable <= writedata[UWB_CTRL_WAKE_BIT];
                syncMode          <= writedata[UWB_CTRL_SYNC_BIT];
                sleepMode         <= writedata[UWB_CTRL_SLEEP_BIT];
            end
            if (breakEnd)
            begin
                wakeOnBreakEnable <= 1'b0;
            end
        end
    end

    // flag set on wake or character
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            receiveInterruptFlag <= 1'b0;
        end
        else if (wakeEvent || charDone)
        begin
            receiveInterruptFlag <= 1'b1;
        end
        else if (bufRead)
        begin
            receiveInterruptFlag <= 1'b0;
        end
    end

    // Receiver. Wake monitoring uses only the synchronised edges, so it
    // keeps working while sleep stops the baud counter.
    // independent of processor mode
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state                 <= UWB_IDLE;
            baudCount             <= '0;
            bitIndex              <= 3'h0;
            shiftReg              <= 8'h00;
            receiveBufferRegister <= UWB_RST_RXBUF;
            frameError            <= 1'b0;
            charDone              <= 1'b0;
        end
        else
        begin
            charDone <= 1'b0;
            case (state)
                UWB_IDLE:
                begin
                    baudCount <= '0;
                    bitIndex  <= 3'h0;
                    if (wakeEvent)
                    begin
                        state <= UWB_WAKE;
                    end
                    else if (!armed && baudRun && fallPulse)
                    begin
                        state <= UWB_START;
                    end
                end
                UWB_WAKE:
                begin
                    // later bits are then taken as a fresh character
                    if (breakEnd || !armed)
                    begin
                        state <= UWB_IDLE;
                    end
                end
                UWB_START, UWB_DATA, UWB_STOP:
                begin
                    if (!baudRun)
                    begin
                        state <= UWB_IDLE;
                    end
                    else if (state == UWB_START
                             && baudCount == CW'(BIT_CYCLES / 2))
                    begin
                        baudCount <= '0;
                        state     <= lineLevel ? UWB_IDLE : UWB_DATA;
                    end
                    else if (state != UWB_START && baudCount == CW'(BIT_CYCLES - 1))
                    begin
                        baudCount <= '0;
                        if (state == UWB_DATA)
                        begin
                            shiftReg <= {lineLevel, shiftReg[7:1]};
                            bitIndex <= bitIndex + 3'h1;
                            if (bitIndex == 3'h7)
                            begin
                                state <= UWB_STOP;
                            end
                        end
                        else
                        begin
                            receiveBufferRegister <= shiftReg;
                            frameError            <= !lineLevel;
                            charDone              <= 1'b1;
                            state                 <= UWB_IDLE;
                        end
                    end
                    else
                    begin
                        baudCount <= baudCount + CW'(1);
                    end
                end
                default:
                begin
                    state <= UWB_IDLE;
                end
            endcase
        end
    end

    wake_sets_flag_a: assert property (@(posedge clock) disable iff (rst)
        wakeEvent |=> receiveInterruptFlag)
        else $error("Wake event did not set the receive flag.");

    break_end_clear_a: assert property (@(posedge clock) disable iff (rst)
        breakEnd |=> !wakeOnBreakEnable && state == UWB_IDLE)
        else $error("Break end did not clear wake enable.");

    armed_no_rx_a: assert property (@(posedge clock) disable iff (rst)
        armed && state == UWB_IDLE |=> state inside {UWB_IDLE, UWB_WAKE})
        else $error("Reception started while wake armed.");

    sync_no_wake_a: assert property (@(posedge clock) disable iff (rst)
        syncMode |-> !wakeEvent)
        else $error("Wake event in synchronous mode.");

    sleep_no_char_a: assert property (@(posedge clock) disable iff (rst)
        sleepMode |=> !charDone)
        else $error("Character completed during sleep.");

    read_clears_flag_a: assert property (@(posedge clock) disable iff (rst)
        bufRead && !wakeEvent && !charDone |=> !receiveInterruptFlag)
        else $error("Buffer read did not clear flag.");

    sleep_wake_a: assert property (@(posedge clock) disable iff (rst)
        sleepMode && armed && state == UWB_IDLE && fallPulse |=> state == UWB_WAKE)
        else $error("Wake missed in sleep.");

    fall_wakes_a: assert property (@(posedge clock) disable iff (rst)
        $fell(lineLevel) && armed && state == UWB_IDLE |-> wakeEvent)
        else $error("Falling edge while armed was not a wake.");

    wake_cov_c: cover property (@(posedge clock) disable iff (rst)
        wakeEvent ##[1:1000] breakEnd);
    char_cov_c: cover property (@(posedge clock) disable iff (rst) charDone);
    sleep_cov_c: cover property (@(posedge clock) disable iff (rst)
        sleepMode && wakeEvent);
endmodule

// ---- tb/uwb_remote_tx.sv ----
`timescale 1ns/100ps
module uwb_remote_tx
#(
    parameter int BIT_CYCLES = 16
)
(
    // Clock
    input  wire logic clock,
    // Serial line
    output logic      lineOut
);
    initial lineOut = 1'b1;

    // Every level is held a whole number of bit times, the first bit cycle included.
    task automatic drive_bits(input logic lvl, input int bits);
        @(posedge clock);
        lineOut <= lvl;
        repeat (bits * BIT_CYCLES - 1) @(posedge clock);
    endtask

    task automatic hold_low(input int bits);
        drive_bits(1'b0, bits);
    endtask

    task automatic hold_idle(input int bits);
        drive_bits(1'b1, bits);
    endtask

    task automatic send_char(input logic [7:0] data);
        drive_bits(1'b0, 1);
        for (int i = 0; i < 8; i++)
        begin
            drive_bits(data[i], 1);
        end
        drive_bits(1'b1, 2);
    endtask
endmodule

// ---- tb/tb_uart_auto_wakeup_on_break.sv ----
`timescale 1ns/100ps
module tb_uart_auto_wakeup_on_break;
    import uwb_pkg::*;
    localparam int BITS = 16;
    logic        clock;
    logic        rst;
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        receiveLinePin;
    logic        receiveInterruptFlag;
    logic        wakeOnBreakEnable;
    int          badCount;
    int          checksDone;

    initial clock = 1'b0;
    always #2.5 clock = ~clock;

    uwb_wake_uart #(.BIT_CYCLES(BITS)) DUT
    (
        .clock                (clock),
        .rst                  (rst),
        .address              (address),
        .read                 (read),
        .write                (write),
        .writedata            (writedata),
        .readdata             (readdata),
        .waitrequest          (waitrequest),
        .receiveLinePin       (receiveLinePin),
        .receiveInterruptFlag (receiveInterruptFlag),
        .wakeOnBreakEnable    (wakeOnBreakEnable)
    );

    uwb_remote_tx #(.BIT_CYCLES(BITS)) remote
    (
        .clock   (clock),
        .lineOut (receiveLinePin)
    );

    task automatic complete_run();
        if (badCount == 0 && checksDone > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checksDone++;
        if (got !== exp)
        begin
            badCount++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // The request stands until the rising edge that samples waitrequest low.
    // Read data are taken at that same edge, and only then is the request released.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        address   <= a;
        writedata <= d;
        read      <= !wr;
        write     <= wr;
        @(posedge clock);
        while (waitrequest !== 1'b0 && n < 100)
        begin
            @(posedge clock);
            n++;
        end
        check(32'(n < 100), 32'h1, "bus answer");
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wait_level(ref logic sig, input logic lvl, input string what);
        int n;
        n = 0;
        @(negedge clock);
        while (sig !== lvl && n < 40)
        begin
            @(negedge clock);
            n++;
        end
        check(32'(sig), 32'(lvl), what);
    endtask

    task automatic test_reset();
        logic [31:0] q;
        bus(1'b0, UWB_OFS_CTRL, 32'h0, q);
        check(q, 32'h0, "control after reset");
        bus(1'b0, UWB_OFS_STATUS, 32'h0, q);
        check(q & 32'h7, 32'h6, "status after reset");
        bus(1'b1, 4'hc, 32'hffff_ffff, q);
        bus(1'b0, 4'hc, 32'h0, q);
        check(q, 32'h0, "unmapped read");
        bus(1'b0, UWB_OFS_CTRL, 32'h0, q);
        check(q, 32'h0, "control after unmapped write");
    endtask

    task automatic test_wake(input logic [31:0] ctrl, input int lowBits);
        logic [31:0] q;
        bus(1'b0, UWB_OFS_STATUS, 32'h0, q);
        check(q & 32'h2, 32'h2, "receiver idle before arming");
        bus(1'b1, UWB_OFS_CTRL, ctrl, q);
        @(negedge clock);
        check(32'(wakeOnBreakEnable), 32'h1, "wake armed");
        bus(1'b0, UWB_OFS_STATUS, 32'h0, q);
        check(q & 32'ha, 32'h2, "receiver idle while armed");
        fork
            remote.hold_low(lowBits);
            begin
                wait_level(receiveInterruptFlag, 1'b1, "flag on falling edge");
                check(32'(wakeOnBreakEnable), 32'h1, "armed while low");
                bus(1'b0, UWB_OFS_STATUS, 32'h0, q);
                check(q & 32'h9, 32'h9, "flag set and break seen");
            end
        join
        fork
            remote.hold_idle(4);
            wait_level(wakeOnBreakEnable, 1'b0, "enable cleared on rise");
        join
        bus(1'b0, UWB_OFS_RXBUF, 32'h0, q);
        bus(1'b0, UWB_OFS_STATUS, 32'h0, q);
        check(q & 32'h3, 32'h2, "flag cleared, receiver idle");
        bus(1'b1, UWB_OFS_CTRL, 32'h0, q);
    endtask

    // A non-zero character while armed: its first rise ends the break, the rest is a fragment.
    task automatic test_fragment();
        logic [31:0] q;
        bus(1'b1, UWB_OFS_CTRL, 32'h1, q);
        fork
            remote.send_char(8'h01);
            wait_level(wakeOnBreakEnable, 1'b0, "enable cleared by first rise");
        join
        remote.hold_idle(2);
        bus(1'b0, UWB_OFS_RXBUF, 32'h0, q);
        check(q & 32'hff, 32'hc0, "fragment of non-zero character");
        bus(1'b0, UWB_OFS_STATUS, 32'h0, q);
        check(q & 32'h1, 32'h0, "flag cleared after fragment read");
    endtask

    task automatic test_quiet(input logic [31:0] ctrl, input string what);
        logic [31:0] q;
        bus(1'b1, UWB_OFS_CTRL, ctrl, q);
        remote.send_char(8'h00);
        remote.send_char(8'h3c);
        check(32'(receiveInterruptFlag), 32'h0, what);
        bus(1'b1, UWB_OFS_CTRL, 32'h0, q);
    endtask

    task automatic test_char();
        logic [31:0] q;
        remote.send_char(8'ha5);
        wait_level(receiveInterruptFlag, 1'b1, "flag on character");
        bus(1'b0, UWB_OFS_RXBUF, 32'h0, q);
        check(q & 32'hff, 32'ha5, "character after wake");
        bus(1'b0, UWB_OFS_STATUS, 32'h0, q);
        check(q & 32'h1, 32'h0, "flag cleared by read");
    endtask

    initial
    begin
        rst        = 1'b1;
        read       = 1'b0;
        write      = 1'b0;
        address    = 4'h0;
        writedata  = 32'h0;
        badCount   = 0;
        checksDone = 0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        test_reset();
        test_wake(32'h1, 13);
        test_wake(32'h5, 10);
        test_wake(32'h1, 1);
        test_fragment();
        test_quiet(32'h3, "no wake in synchronous mode");
        test_quiet(32'h4, "no reception in sleep");
        test_char();
        complete_run();
    end

    // The tests need about 1800 cycles; over thirteen times that means a hang.
    initial
    begin
        repeat (24000) @(posedge clock);
        badCount++;
        complete_run();
    end
endmodule
